// ===== rtl/tvm_regs.sv
// Temperature and supply monitor register bank with interrupt output.
// Assumes comparator and mode inputs already synchronous to mclk.
//
// The plain strobed port was left to the implementer.
`default_nettype none

module tvm_regs #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Analog side and modes
   input wire logic hotCompare,
   input wire logic undervoltCompare,
   input wire logic fullPerformanceMode,
   input wire logic specialMode,
   // Converter routing and sensor control
   output logic tempSenseEnable,
   output logic voltageRouteEnable,
   output logic voltageSourceSelect,
   // Interrupt
   output logic irq
);

   // ****************************************
   // Elaboration check
   // ****************************************
   generate
      if (ADDR_W < 10 || ADDR_W > 16) begin : g_bad_addr
         $error("ADDR_W must lie between 10 and 16");
      end
   endgenerate

   // ****************************************
   // State
   // ****************************************
   logic [1:0] testBits_reg, testBits_next;
   logic srcSel_reg, srcSel_next;
   logic routeEn_reg, routeEn_next;
   logic senseEn_reg, senseEn_next;
   logic hotStatus_reg, hotStatus_next;
   logic hotIe_reg, hotIe_next;
   logic hotFlag_reg, hotFlag_next;
   logic uvStatus_reg, uvStatus_next;
   logic uvIe_reg, uvIe_next;
   logic uvFlag_reg, uvFlag_next;
   logic irq_reg, irq_next;
   logic [7:0] rdata_reg, rdata_next;

   logic wrTemp, wrUv, wrClr, wrEn;
   logic hotClear, uvClear;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] target);
      hit = (a == target[ADDR_W-1:0]);
   endfunction

   assign wrTemp = regWr && hit(regAddr, tvm_pkg::TEMP_CTRL_ADDR);
   assign wrUv = regWr && hit(regAddr, tvm_pkg::UV_CTRL_ADDR);
   assign wrClr = regWr && hit(regAddr, tvm_pkg::IRQ_CLR_ADDR);
   assign wrEn = regWr && hit(regAddr, tvm_pkg::IRQ_EN_ADDR);

   // Clear strobes from either the control register or the summary clear
   assign hotClear = (wrTemp && regWdata[tvm_pkg::FLAG_BIT])
      || (wrClr && regWdata[tvm_pkg::SUM_HOT_BIT]);
   assign uvClear = (wrUv && regWdata[tvm_pkg::FLAG_BIT])
      || (wrClr && regWdata[tvm_pkg::SUM_UV_BIT]);

   // ****************************************
   // Control bits
   // ****************************************
   always_comb begin
      testBits_next = testBits_reg;
      srcSel_next = srcSel_reg;
      routeEn_next = routeEn_reg;
      senseEn_next = senseEn_reg;
      hotIe_next = hotIe_reg;
      uvIe_next = uvIe_reg;
      if (wrTemp) begin
         if (specialMode) begin
            testBits_next = regWdata[tvm_pkg::TEST_HI_BIT:tvm_pkg::TEST_LO_BIT]; // RULE1
         end
         srcSel_next = regWdata[tvm_pkg::SRC_SEL_BIT]; // RULE2
         routeEn_next = regWdata[tvm_pkg::ROUTE_EN_BIT]; // RULE3
         senseEn_next = regWdata[tvm_pkg::SENSE_EN_BIT]; // RULE4
         hotIe_next = regWdata[tvm_pkg::IRQ_EN_BIT];
      end
      if (wrUv) begin
         uvIe_next = regWdata[tvm_pkg::IRQ_EN_BIT];
      end
      if (wrEn) begin
         hotIe_next = regWdata[tvm_pkg::SUM_HOT_BIT];
         uvIe_next = regWdata[tvm_pkg::SUM_UV_BIT];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         testBits_reg <= tvm_pkg::TEST_RESET;
         srcSel_reg <= 1'b0;
         routeEn_reg <= 1'b0;
         senseEn_reg <= 1'b0;
         hotIe_reg <= 1'b0; // RULE16
         uvIe_reg <= 1'b0; // RULE16
      end else begin
         testBits_reg <= testBits_next;
         srcSel_reg <= srcSel_next;
         routeEn_reg <= routeEn_next;
         senseEn_reg <= senseEn_next;
         hotIe_reg <= hotIe_next;
         uvIe_reg <= uvIe_next;
      end
   end

   // ****************************************
   // Status and change flags
   // ****************************************
   // Mode loss forces status low, which itself counts as a change
   always_comb begin
      hotStatus_next = hotCompare && senseEn_reg && fullPerformanceMode; // RULE5 RULE6
      uvStatus_next = undervoltCompare && fullPerformanceMode; // RULE10 RULE11
      hotFlag_next = hotFlag_reg;
      uvFlag_next = uvFlag_reg;
      if (hotStatus_next != hotStatus_reg) begin
         hotFlag_next = 1'b1; // RULE8
      end
      if (hotClear) begin
         hotFlag_next = 1'b0; // RULE16 RULE8
      end
      if (uvStatus_next != uvStatus_reg) begin
         uvFlag_next = 1'b1; // RULE13
      end
      if (uvClear) begin
         uvFlag_next = 1'b0; // RULE16 RULE13
      end
      // Nothing else touches the flags, so power mode entry keeps them unless its forced status drop sets them
      irq_next = (hotFlag_reg && hotIe_reg) || (uvFlag_reg && uvIe_reg); // RULE7 RULE12 RULE9 RULE14
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hotStatus_reg <= 1'b0;
         uvStatus_reg <= 1'b0;
         hotFlag_reg <= 1'b0; // RULE16
         uvFlag_reg <= 1'b0; // RULE16
         irq_reg <= 1'b0;
      end else begin
         hotStatus_reg <= hotStatus_next;
         uvStatus_reg <= uvStatus_next;
         hotFlag_reg <= hotFlag_next;
         uvFlag_reg <= uvFlag_next;
         irq_reg <= irq_next;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      rdata_next = tvm_pkg::DATA_ZERO;
      if (regRd) begin
         if (hit(regAddr, tvm_pkg::TEMP_CTRL_ADDR)) begin
            rdata_next[tvm_pkg::TEST_HI_BIT:tvm_pkg::TEST_LO_BIT] = testBits_reg;
            rdata_next[tvm_pkg::SRC_SEL_BIT] = srcSel_reg;
            rdata_next[tvm_pkg::ROUTE_EN_BIT] = routeEn_reg;
            rdata_next[tvm_pkg::SENSE_EN_BIT] = senseEn_reg;
            rdata_next[tvm_pkg::STATUS_BIT] = hotStatus_reg;
            rdata_next[tvm_pkg::IRQ_EN_BIT] = hotIe_reg;
            rdata_next[tvm_pkg::FLAG_BIT] = hotFlag_reg;
         end else if (hit(regAddr, tvm_pkg::UV_CTRL_ADDR)) begin
            rdata_next[tvm_pkg::STATUS_BIT] = uvStatus_reg; // RULE15
            rdata_next[tvm_pkg::IRQ_EN_BIT] = uvIe_reg;
            rdata_next[tvm_pkg::FLAG_BIT] = uvFlag_reg;
         end else if (hit(regAddr, tvm_pkg::IRQ_STAT_ADDR)) begin
            rdata_next[tvm_pkg::SUM_HOT_BIT] = hotFlag_reg;
            rdata_next[tvm_pkg::SUM_UV_BIT] = uvFlag_reg;
         end else if (hit(regAddr, tvm_pkg::IRQ_EN_ADDR)) begin
            rdata_next[tvm_pkg::SUM_HOT_BIT] = hotIe_reg;
            rdata_next[tvm_pkg::SUM_UV_BIT] = uvIe_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= tvm_pkg::DATA_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign regRdata = rdata_reg;
   assign tempSenseEnable = senseEn_reg;
   assign voltageRouteEnable = routeEn_reg;
   assign voltageSourceSelect = srcSel_reg;
   assign irq = irq_reg;

   // ****************************************
   // Assertions
   // ****************************************
   property p_testLock;
      @(posedge mclk) disable iff (!resetn)
      (wrTemp && !specialMode) |=> $stable(testBits_reg);
   endproperty
   a_testLock: assert property (p_testLock) else $error("test bits changed outside special mode"); // RULE1

   property p_routeWrite;
      @(posedge mclk) disable iff (!resetn)
      wrTemp |=> (voltageRouteEnable == $past(regWdata[tvm_pkg::ROUTE_EN_BIT]))
         && (voltageSourceSelect == $past(regWdata[tvm_pkg::SRC_SEL_BIT]))
         && (tempSenseEnable == $past(regWdata[tvm_pkg::SENSE_EN_BIT]));
   endproperty
   a_routeWrite: assert property (p_routeWrite) else $error("routing bits not taken from write"); // RULE3

   property p_hotStatus;
      @(posedge mclk) disable iff (!resetn)
      (hotCompare && senseEn_reg && fullPerformanceMode) |=> hotStatus_reg;
   endproperty
   a_hotStatus: assert property (p_hotStatus) else $error("hot status missed"); // RULE6

   property p_hotOffMode;
      @(posedge mclk) disable iff (!resetn)
      !fullPerformanceMode |=> !hotStatus_reg && !uvStatus_reg;
   endproperty
   a_hotOffMode: assert property (p_hotOffMode) else $error("status high outside full mode"); // RULE11

   property p_hotSet;
      @(posedge mclk) disable iff (!resetn)
      (hotStatus_reg != $past(hotStatus_reg)) && !$past(hotClear) |-> hotFlag_reg;
   endproperty
   a_hotSet: assert property (p_hotSet) else $error("hot flag not set on change"); // RULE8

   property p_uvSet;
      @(posedge mclk) disable iff (!resetn)
      (uvStatus_reg != $past(uvStatus_reg)) && !$past(uvClear) |-> uvFlag_reg;
   endproperty
   a_uvSet: assert property (p_uvSet) else $error("undervoltage flag not set on change"); // RULE13

   property p_clearWins;
      @(posedge mclk) disable iff (!resetn)
      hotClear |=> !hotFlag_reg;
   endproperty
   a_clearWins: assert property (p_clearWins) else $error("hot flag survived a clear"); // RULE16

   property p_flagKeep;
      @(posedge mclk) disable iff (!resetn)
      uvFlag_reg && !uvClear ##1 $fell(fullPerformanceMode) && !uvClear ##1 !uvClear
         |-> uvFlag_reg [*2];
   endproperty
   a_flagKeep: assert property (p_flagKeep) else $error("flag lost on power mode entry"); // RULE14

   property p_irq;
      @(posedge mclk) disable iff (!resetn)
      (hotFlag_reg && hotIe_reg) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE7

   property p_irqMasked;
      @(posedge mclk) disable iff (!resetn)
      !(hotFlag_reg && hotIe_reg) && !(uvFlag_reg && uvIe_reg) |=> !irq;
   endproperty
   a_irqMasked: assert property (p_irqMasked) else $error("interrupt without enabled flag"); // RULE12

   property p_uvUpper;
      @(posedge mclk) disable iff (!resetn)
      (regRd && hit(regAddr, tvm_pkg::UV_CTRL_ADDR))
         |=> (regRdata[tvm_pkg::TEST_HI_BIT:tvm_pkg::SENSE_EN_BIT] == 5'h00)
         && (regRdata[tvm_pkg::STATUS_BIT] == $past(uvStatus_reg));
   endproperty
   a_uvUpper: assert property (p_uvUpper) else $error("undervoltage upper bits not zero"); // RULE15

   // ****************************************
   // Flag and interrupt assertions
   // ****************************************
   property p_hotKeep;
      @(posedge mclk) disable iff (!resetn)
      hotFlag_reg && !hotClear ##1 $fell(fullPerformanceMode) && !hotClear ##1 !hotClear
         |-> hotFlag_reg [*2];
   endproperty
   a_hotKeep: assert property (p_hotKeep) else $error("hot flag lost on power mode entry"); // RULE9

   property p_uvIrq;
      @(posedge mclk) disable iff (!resetn)
      (uvFlag_reg && uvIe_reg) |=> irq;
   endproperty
   a_uvIrq: assert property (p_uvIrq) else $error("undervoltage interrupt missing"); // RULE12

   property p_uvClearWins;
      @(posedge mclk) disable iff (!resetn)
      uvClear |=> !uvFlag_reg;
   endproperty
   a_uvClearWins: assert property (p_uvClearWins) else $error("undervoltage flag survived a clear"); // RULE16

   property p_hotHold;
      @(posedge mclk) disable iff (!resetn)
      hotFlag_reg && !hotClear |=> hotFlag_reg;
   endproperty
   a_hotHold: assert property (p_hotHold) else $error("hot flag dropped without a clear"); // RULE8

   property p_uvHold;
      @(posedge mclk) disable iff (!resetn)
      uvFlag_reg && !uvClear |=> uvFlag_reg;
   endproperty
   a_uvHold: assert property (p_uvHold) else $error("undervoltage flag dropped without a clear"); // RULE13

   property p_hotNoSpurious;
      @(posedge mclk) disable iff (!resetn)
      !hotFlag_reg && (hotStatus_next == hotStatus_reg) |=> !hotFlag_reg;
   endproperty
   a_hotNoSpurious: assert property (p_hotNoSpurious) else $error("hot flag set without change"); // RULE8

   property p_uvNoSpurious;
      @(posedge mclk) disable iff (!resetn)
      !uvFlag_reg && (uvStatus_next == uvStatus_reg) |=> !uvFlag_reg;
   endproperty
   a_uvNoSpurious: assert property (p_uvNoSpurious) else $error("undervoltage flag set without change"); // RULE13

   property p_enAlias;
      @(posedge mclk) disable iff (!resetn)
      wrEn |=> (hotIe_reg == $past(regWdata[tvm_pkg::SUM_HOT_BIT]))
         && (uvIe_reg == $past(regWdata[tvm_pkg::SUM_UV_BIT]));
   endproperty
   a_enAlias: assert property (p_enAlias) else $error("enable register not taken from write"); // RULE12

   // ****************************************
   // Status, control and read assertions
   // ****************************************
   property p_uvStatus;
      @(posedge mclk) disable iff (!resetn)
      (undervoltCompare && fullPerformanceMode) |=> uvStatus_reg;
   endproperty
   a_uvStatus: assert property (p_uvStatus) else $error("undervoltage status missed"); // RULE11

   property p_hotStatusLow;
      @(posedge mclk) disable iff (!resetn)
      !(hotCompare && senseEn_reg && fullPerformanceMode) |=> !hotStatus_reg;
   endproperty
   a_hotStatusLow: assert property (p_hotStatusLow) else $error("hot status high without cause"); // RULE6

   property p_uvStatusLow;
      @(posedge mclk) disable iff (!resetn)
      !(undervoltCompare && fullPerformanceMode) |=> !uvStatus_reg;
   endproperty
   a_uvStatusLow: assert property (p_uvStatusLow) else $error("undervoltage status high without cause"); // RULE10

   property p_ctrlHold;
      @(posedge mclk) disable iff (!resetn)
      !wrTemp |=> $stable({voltageSourceSelect, voltageRouteEnable, tempSenseEnable});
   endproperty
   a_ctrlHold: assert property (p_ctrlHold) else $error("routing bits changed without a write"); // RULE4

   property p_testHold;
      @(posedge mclk) disable iff (!resetn)
      !wrTemp |=> $stable(testBits_reg);
   endproperty
   a_testHold: assert property (p_testHold) else $error("test bits changed without a write"); // RULE1

   property p_hotRead;
      @(posedge mclk) disable iff (!resetn)
      (regRd && hit(regAddr, tvm_pkg::TEMP_CTRL_ADDR))
         |=> (regRdata[tvm_pkg::STATUS_BIT] == $past(hotStatus_reg));
   endproperty
   a_hotRead: assert property (p_hotRead) else $error("hot status read back wrong"); // RULE5

   property p_testRead;
      @(posedge mclk) disable iff (!resetn)
      (regRd && hit(regAddr, tvm_pkg::TEMP_CTRL_ADDR))
         |=> (regRdata[tvm_pkg::TEST_HI_BIT:tvm_pkg::TEST_LO_BIT] == $past(testBits_reg));
   endproperty
   a_testRead: assert property (p_testRead) else $error("test bits read back wrong"); // RULE1

endmodule

`default_nettype wire

// ===== rtl/tvm_pkg.sv
// Constants for the temperature and supply monitor register bank.
// Assumes a single clock and byte-wide register port.
// How it works
// RULE1: Test bits 7 and 6 of the temperature control register change only in special mode and stay zero otherwise; here a special-mode write persists.
// RULE2: Select bit 5 at zero offers the temperature voltage, at one the bandgap voltage.
// RULE3: Route enable bit 4 connects the selected voltage to the converter, else the external input stays.
// RULE4: Temperature sensing runs only while enable bit 3 is one.
// RULE5: The hot status bit is read-only and follows the sensor comparison.
// RULE6: Hot status is one only while hot in full performance mode, else zero.
// RULE7: A set hot change flag raises the interrupt while its enable bit is one.
// RULE8: Any change of hot status sets the hot flag; writing one clears it, zero keeps it.
// RULE9: Entering reduced power mode leaves the hot flag as it is; here the forced status drop sets it if hot status was one.
// RULE10: The undervoltage status bit is read-only and follows the supply comparison.
// RULE11: Undervoltage status is one only while low in full performance mode, else zero.
// RULE12: A set undervoltage flag raises the interrupt while its enable bit is one.
// RULE13: Any change of undervoltage status sets its flag; writing one clears it, zero keeps it.
// RULE14: Entering reduced power mode leaves the undervoltage flag as it is; here the forced status drop sets it if its status was one.
// RULE15: The upper five bits of the undervoltage control register read as zero.
// RULE16: A clear wins over a simultaneous status change, and flags and enables reset to zero.
`default_nettype none

package tvm_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] TEMP_CTRL_ADDR = 16'h02F0;
   localparam logic [15:0] UV_CTRL_ADDR = 16'h02F1;
   localparam logic [15:0] IRQ_STAT_ADDR = 16'h02F8;
   localparam logic [15:0] IRQ_CLR_ADDR = 16'h02F9;
   localparam logic [15:0] IRQ_EN_ADDR = 16'h02FA;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TEST_HI_BIT = 7;
   localparam int TEST_LO_BIT = 6;
   localparam int SRC_SEL_BIT = 5;
   localparam int ROUTE_EN_BIT = 4;
   localparam int SENSE_EN_BIT = 3;
   localparam int STATUS_BIT = 2;
   localparam int IRQ_EN_BIT = 1;
   localparam int FLAG_BIT = 0;
   // Layout of the interrupt summary registers
   localparam int SUM_HOT_BIT = 0;
   localparam int SUM_UV_BIT = 1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [1:0] TEST_RESET = 2'h0;

endpackage

`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the temperature and supply monitor register bank.
// Assumes tvm_pkg compiled first; the bench drives every input of tvm_regs itself.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals and instance
   // ****************************************
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic hotCompare = 1'b0;
   logic undervoltCompare = 1'b0;
   logic fullPerformanceMode = 1'b1;
   logic specialMode = 1'b0;
   logic tempSenseEnable;
   logic voltageRouteEnable;
   logic voltageSourceSelect;
   logic irq;
   int bad_count = 0;
   int comparisons = 0;

   tvm_regs #(.ADDR_W(16)) DUT (
      .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hotCompare(hotCompare),
      .undervoltCompare(undervoltCompare), .fullPerformanceMode(fullPerformanceMode),
      .specialMode(specialMode), .tempSenseEnable(tempSenseEnable),
      .voltageRouteEnable(voltageRouteEnable), .voltageSourceSelect(voltageSourceSelect), .irq(irq)
   );

   initial begin
      forever #2 mclk = ~mclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // Data sampled just after the edge that registers them
   task automatic rd_check(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      check(what, regRdata, exp);
   endtask

   // Status and flag lag one cycle, irq one more
   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask

   function automatic logic [7:0] outs();
      return {5'h00, voltageSourceSelect, voltageRouteEnable, tempSenseEnable};
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      check("outs", outs(), 8'h00);
      check("irq", {7'h00, irq}, 8'h00);
      rd_check("temp", tvm_pkg::TEMP_CTRL_ADDR, 8'h00);
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h00);
   endtask

   task automatic t_control();
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'hFF);
      settle();
      check("outs", outs(), 8'h07);
      rd_check("temp", tvm_pkg::TEMP_CTRL_ADDR, 8'h3A);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h2A);
      settle();
      check("outs", outs(), 8'h05);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h12);
      settle();
      check("outs", outs(), 8'h02);
      @(posedge mclk);
      specialMode <= 1'b1;
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'hC0);
      rd_check("test", tvm_pkg::TEMP_CTRL_ADDR, 8'hC0);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h00);
      specialMode <= 1'b0;
      rd_check("test", tvm_pkg::TEMP_CTRL_ADDR, 8'h00);
   endtask

   task automatic t_hot();
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h3A);
      @(posedge mclk);
      hotCompare <= 1'b1;
      settle();
      check("irq", {7'h00, irq}, 8'h01);
      rd_check("hot", tvm_pkg::TEMP_CTRL_ADDR, 8'h3F);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h3A);
      rd_check("hot", tvm_pkg::TEMP_CTRL_ADDR, 8'h3F);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h3B);
      rd_check("hot", tvm_pkg::TEMP_CTRL_ADDR, 8'h3E);
      check("irq", {7'h00, irq}, 8'h00);
      // Flag set while still in full mode, so entry itself causes no change
      @(posedge mclk);
      hotCompare <= 1'b0;
      settle();
      rd_check("cool", tvm_pkg::TEMP_CTRL_ADDR, 8'h3B);
      @(posedge mclk);
      fullPerformanceMode <= 1'b0;
      settle();
      rd_check("rpm", tvm_pkg::TEMP_CTRL_ADDR, 8'h3B);
      @(posedge mclk);
      hotCompare <= 1'b1;
      settle();
      rd_check("rpm", tvm_pkg::TEMP_CTRL_ADDR, 8'h3B);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h38);
      settle();
      check("irq", {7'h00, irq}, 8'h00);
      wr(tvm_pkg::TEMP_CTRL_ADDR, 8'h01);
      rd_check("hot", tvm_pkg::TEMP_CTRL_ADDR, 8'h00);
      @(posedge mclk);
      hotCompare <= 1'b0;
   endtask

   task automatic t_undervolt();
      fullPerformanceMode <= 1'b1;
      wr(tvm_pkg::UV_CTRL_ADDR, 8'hFF);
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h02);
      // Status change and flag clear land on one edge
      fork
         wr(tvm_pkg::UV_CTRL_ADDR, 8'h03);
         begin
            @(posedge mclk);
            undervoltCompare <= 1'b1;
         end
      join
      rd_check("prio", tvm_pkg::UV_CTRL_ADDR, 8'h06);
      @(posedge mclk);
      undervoltCompare <= 1'b0;
      wr(tvm_pkg::IRQ_CLR_ADDR, 8'h02);
      @(posedge mclk);
      undervoltCompare <= 1'b1;
      settle();
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h07);
      check("irq", {7'h00, irq}, 8'h01);
      rd_check("sum", tvm_pkg::IRQ_STAT_ADDR, 8'h02);
      rd_check("en", tvm_pkg::IRQ_EN_ADDR, 8'h02);
      wr(tvm_pkg::UV_CTRL_ADDR, 8'h02);
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h07);
      wr(tvm_pkg::IRQ_CLR_ADDR, 8'h02);
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h06);
      check("irq", {7'h00, irq}, 8'h00);
      rd_check("clr", tvm_pkg::IRQ_CLR_ADDR, 8'h00);
      @(posedge mclk);
      undervoltCompare <= 1'b0;
      wr(tvm_pkg::IRQ_EN_ADDR, 8'h00);
      fullPerformanceMode <= 1'b0;
      settle();
      rd_check("uv", tvm_pkg::UV_CTRL_ADDR, 8'h01);
      check("irq", {7'h00, irq}, 8'h00);
      wr(tvm_pkg::IRQ_EN_ADDR, 8'h02);
      settle();
      check("irq", {7'h00, irq}, 8'h01);
      wr(16'h02F6, 8'hFF);
      rd_check("gap", 16'h02F6, 8'h00);
   endtask

   // ****************************************
   // Sequence, verdict and watchdog
   // ****************************************
   task automatic tally_and_finish();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      t_reset();
      t_control();
      t_hot();
      t_undervolt();
      tally_and_finish();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
